//--- src/can_txrq_pkg.sv
package can_txrq_pkg;

    // Object store geometry
    localparam int NUM_OBJ = 32;
    localparam int OBJ_W = 5;
    localparam int ADDR_W = 12;
    localparam int ID_W = 29;
    localparam int FLAG_W = 4;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] IF_ID_OFS = 12'h004;
    localparam logic [11:0] IF_DATA_OFS = 12'h008;
    localparam logic [11:0] IF_XFER_OFS = 12'h00c;
    localparam logic [11:0] PEND_OFS = 12'h010;
    localparam logic [11:0] OBJ_BASE_OFS = 12'h100;

    // Object window decode: base bits above the index, index position
    localparam int OBJ_IDX_LSB = 2;
    localparam int OBJ_BASE_LSB = 7;

    // Per-object flag field positions
    localparam int FLAG_RQST = 0;
    localparam int FLAG_NEW_DATA_FLAG = 1;
    localparam int FLAG_INTERRUPT_PENDING_FLAG = 2;
    localparam int FLAG_TRANSMIT_INTERRUPT_ENABLE = 3;

    // Control register field positions
    localparam int CTRL_DAR_BIT = 0;
    localparam int CTRL_ST_LSB = 8;
    localparam int CTRL_BLK_BIT = 16;
    localparam int CTRL_CUR_LSB = 24;

    // Transfer command: object index low, flags from this bit up
    localparam int XFER_FLAG_LSB = 8;

    // Reset values
    localparam logic CTRL_DAR_RST = 1'b0;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;

    // Transmit engine states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PREP = 2'b01,
        TX_BUSY = 2'b10
    } tx_state_e;

endpackage

//--- src/can_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none

// Lowest set index wins, so object 1 (index 0) has the highest priority
module can_prio_enc
    import can_txrq_pkg::*;
#(
    parameter int N = 32,
    parameter int W = 5
)
(
    input wire logic [N-1:0] i_req,
    output logic o_any,
    output logic [W-1:0] o_idx
);

    // Scan downward so the last hit is the lowest index
    always_comb
    begin
        o_idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (i_req[i])
            begin
                o_idx = W'(i);
            end
        end
        o_any = |i_req;
    end

endmodule
`default_nettype wire

//--- src/can_obj_flags.sv
`timescale 1ns/1ps
`default_nettype none

// Control flags of one message object
module can_obj_flags
    import can_txrq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [FLAG_W-1:0] i_wdata,
    input wire logic i_sent,
    input wire logic i_clr,
    input wire logic i_drop,
    output logic [FLAG_W-1:0] o_flags
);

    typedef struct packed {
        logic [FLAG_W-1:0] f;
    } flags_s;

    flags_s st_r;
    flags_s st_nxt;

    // Host load beats engine clears; a completed send still sets pending
    always_comb
    begin
        st_nxt = st_r;
        if (i_wr)
        begin
            st_nxt.f = i_wdata;
            st_nxt.f[FLAG_INTERRUPT_PENDING_FLAG] = i_wdata[FLAG_INTERRUPT_PENDING_FLAG]
                | (i_sent & st_r.f[FLAG_TRANSMIT_INTERRUPT_ENABLE]);
        end
        else
        begin
            if (i_sent && st_r.f[FLAG_TRANSMIT_INTERRUPT_ENABLE])
            begin
                st_nxt.f[FLAG_INTERRUPT_PENDING_FLAG] = 1'b1;
            end
            if (i_clr)
            begin
                st_nxt.f[FLAG_RQST] = 1'b0;
                st_nxt.f[FLAG_NEW_DATA_FLAG] = 1'b0;
            end
            if (i_drop)
            begin
                st_nxt.f[FLAG_RQST] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_r <= '{f: FLAGS_RST};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_flags = st_r.f;

    // A drop alone touches only the request bit
    drop_keeps_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_drop && !i_wr && !i_sent) |=> o_flags[FLAG_W-1:1] == $past(o_flags[FLAG_W-1:1]))
        else $error("drop changed new-data or pending flag");

endmodule
`default_nettype wire

//--- src/can_txrq.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A sent object loses request and new-data; pending sets only if enabled.
// - A request dropped without sending keeps new-data and pending unchanged.
// - Normal mode retries and serves every pending request, no count limit.
// - Lower object number wins; object 32 is lowest priority.
// - A blocked request re-arms on bus activity or any request being set.
// - Transferred content goes next; an ongoing send never alters it.
module can_txrq
    import can_txrq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_tx_start,
    input wire logic i_tx_done,
    input wire logic i_tx_fail,
    input wire logic i_bus_activity,
    output logic o_tx_valid,
    output logic [OBJ_W-1:0] o_tx_obj,
    output logic [ID_W-1:0] o_tx_id,
    output logic [31:0] o_tx_data
);

    typedef struct packed {
        logic retransmission_disable;
        logic [ID_W-1:0] if_id;
        logic [31:0] if_data;
        logic [NUM_OBJ-1:0][ID_W-1:0] obj_id;
        logic [NUM_OBJ-1:0][31:0] obj_data;
        tx_state_e st;
        logic [OBJ_W-1:0] cur;
        logic changed;
        logic blocked;
        logic [ID_W-1:0] tx_id;
        logic [31:0] tx_data;
        logic [31:0] rdata;
    } core_s;

    core_s st_r;
    core_s st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [NUM_OBJ-1:0] obj_wr;
    logic [FLAG_W-1:0] obj_wdata;
    logic [NUM_OBJ-1:0] rqst;
    logic [NUM_OBJ-1:0] new_data_flag;
    logic [NUM_OBJ-1:0] interrupt_pending_flag;
    logic [NUM_OBJ-1:0] transmit_interrupt_enable;
    logic [NUM_OBJ-1:0][FLAG_W-1:0] flags;
    logic any_rq;
    logic [OBJ_W-1:0] enc_idx;
    logic sent;
    logic clr;
    logic drop;
    logic any_set;
    logic obj_sel;
    logic [OBJ_W-1:0] xfer_idx;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Per-object flags and priority pick
    for (genvar g = 0; g < NUM_OBJ; g++)
    begin : g_obj
        can_obj_flags u_flags (
            .i_core_clk(i_core_clk),
            .i_rst_n(rst_n),
            .i_wr(obj_wr[g]),
            .i_wdata(obj_wdata),
            .i_sent(sent && st_r.cur == OBJ_W'(g)),
            .i_clr(clr && st_r.cur == OBJ_W'(g)),
            .i_drop(drop && st_r.cur == OBJ_W'(g)),
            .o_flags(flags[g])
        );
        assign rqst[g] = flags[g][FLAG_RQST];
        assign new_data_flag[g] = flags[g][FLAG_NEW_DATA_FLAG];
        assign interrupt_pending_flag[g] = flags[g][FLAG_INTERRUPT_PENDING_FLAG];
        assign transmit_interrupt_enable[g] = flags[g][FLAG_TRANSMIT_INTERRUPT_ENABLE];
    end

    can_prio_enc #(
        .N(NUM_OBJ),
        .W(OBJ_W)
    ) u_enc (
        .i_req(rqst),
        .o_any(any_rq),
        .o_idx(enc_idx)
    );

    assign obj_sel = i_addr[ADDR_W-1:OBJ_BASE_LSB] == OBJ_BASE_OFS[ADDR_W-1:OBJ_BASE_LSB]
        && i_addr[OBJ_IDX_LSB-1:0] == 2'b00;
    assign xfer_idx = i_wdata[OBJ_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Register writes, transmit engine and read data
    always_comb
    begin
        st_nxt = st_r;
        obj_wr = '0;
        obj_wdata = FLAGS_RST;
        sent = 1'b0;
        clr = 1'b0;
        drop = 1'b0;
        st_nxt.rdata = 32'h0000_0000;

        // Software side
        if (i_wr)
        begin
            case (i_addr)
                CTRL_OFS: st_nxt.retransmission_disable = i_wdata[CTRL_DAR_BIT];
                IF_ID_OFS: st_nxt.if_id = i_wdata[ID_W-1:0];
                IF_DATA_OFS: st_nxt.if_data = i_wdata;
                IF_XFER_OFS:
                begin
                    obj_wr[xfer_idx] = 1'b1;
                    obj_wdata = i_wdata[XFER_FLAG_LSB +: FLAG_W];
                    st_nxt.obj_id[xfer_idx] = st_r.if_id;
                    st_nxt.obj_data[xfer_idx] = st_r.if_data;
                end
                default:
                begin
                    if (obj_sel)
                    begin
                        obj_wr[i_addr[OBJ_IDX_LSB +: OBJ_W]] = 1'b1;
                        obj_wdata = i_wdata[FLAG_W-1:0];
                    end
                end
            endcase
        end
        any_set = (|obj_wr) && obj_wdata[FLAG_RQST];

        // Recovery from a cancelled preparation
        if (any_set || i_bus_activity)
        begin
            st_nxt.blocked = 1'b0;
        end

        case (st_r.st)
            TX_IDLE:
            begin
                if (any_rq && !st_r.blocked)
                begin
                    st_nxt.st = TX_PREP;
                    st_nxt.cur = enc_idx;
                    st_nxt.tx_id = st_r.obj_id[enc_idx];
                    st_nxt.tx_data = st_r.obj_data[enc_idx];
                end
            end
            TX_PREP:
            begin
                // Cancel follows the live flag, so a re-set is seen at once
                if (!rqst[st_r.cur])
                begin
                    st_nxt.st = TX_IDLE;
                    st_nxt.blocked = !any_set;
                end
                else if (i_tx_start)
                begin
                    st_nxt.st = TX_BUSY;
                    st_nxt.changed = obj_wr[st_r.cur];
                end
                else if (i_tx_fail)
                begin
                    // Slot lost before start: no retry in no-retransmit mode
                    st_nxt.st = TX_IDLE;
                    drop = st_r.retransmission_disable && !obj_wr[st_r.cur];
                end
                else
                begin
                    // Keep the offer fresh: higher priority or new content
                    st_nxt.cur = enc_idx;
                    st_nxt.tx_id = st_r.obj_id[enc_idx];
                    st_nxt.tx_data = st_r.obj_data[enc_idx];
                end
            end
            TX_BUSY:
            begin
                if (obj_wr[st_r.cur])
                begin
                    st_nxt.changed = 1'b1;
                end
                if (i_tx_done)
                begin
                    st_nxt.st = TX_IDLE;
                    sent = 1'b1;
                    clr = !st_r.changed && !obj_wr[st_r.cur];
                end
                else if (i_tx_fail)
                begin
                    st_nxt.st = TX_IDLE;
                    // Normal mode keeps the request for the next slot
                    drop = st_r.retransmission_disable && !st_r.changed && !obj_wr[st_r.cur];
                end
            end
            default: st_nxt.st = TX_IDLE;
        endcase

        // Read answer stands only in the cycle after the strobe
        if (i_rd)
        begin
            case (i_addr)
                CTRL_OFS:
                begin
                    st_nxt.rdata[CTRL_DAR_BIT] = st_r.retransmission_disable;
                    st_nxt.rdata[CTRL_ST_LSB +: 2] = st_r.st;
                    st_nxt.rdata[CTRL_BLK_BIT] = st_r.blocked;
                    st_nxt.rdata[CTRL_CUR_LSB +: OBJ_W] = st_r.cur;
                end
                IF_ID_OFS: st_nxt.rdata[ID_W-1:0] = st_r.if_id;
                IF_DATA_OFS: st_nxt.rdata = st_r.if_data;
                PEND_OFS: st_nxt.rdata = rqst;
                default:
                begin
                    if (obj_sel)
                    begin
                        st_nxt.rdata[FLAG_W-1:0] = flags[i_addr[OBJ_IDX_LSB +: OBJ_W]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.retransmission_disable <= CTRL_DAR_RST;
            st_r.st <= TX_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_tx_valid = st_r.st == TX_PREP;
    assign o_tx_obj = st_r.cur;
    assign o_tx_id = st_r.tx_id;
    assign o_tx_data = st_r.tx_data;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_reload;
        st_r.st == TX_BUSY && obj_wr[st_r.cur] && obj_wdata[FLAG_RQST];
    endsequence

    sequence s_finish;
        (st_r.st == TX_BUSY && !(|obj_wr) && !i_tx_done && !i_tx_fail)
            ##1 (i_tx_done && !(|obj_wr));
    endsequence

    sent_clears_a: assert property (
        (st_r.st == TX_BUSY && i_tx_done && !st_r.changed && !(|obj_wr))
        |=> !rqst[$past(st_r.cur)] && !new_data_flag[$past(st_r.cur)])
        else $error("sent object kept request or new-data");

    sent_irq_a: assert property (
        (st_r.st == TX_BUSY && i_tx_done && !(|obj_wr))
        |=> interrupt_pending_flag[$past(st_r.cur)] == $past(transmit_interrupt_enable[st_r.cur] | interrupt_pending_flag[st_r.cur]))
        else $error("pending flag wrong after send");

    fail_keeps_a: assert property (
        (st_r.retransmission_disable && st_r.st == TX_BUSY && i_tx_fail && !i_tx_done && !(|obj_wr)
            && !st_r.changed)
        |=> $stable(new_data_flag) && $stable(interrupt_pending_flag) && !rqst[$past(st_r.cur)])
        else $error("dropped request disturbed other flags");

    normal_retry_a: assert property (
        (!st_r.retransmission_disable && st_r.st == TX_BUSY && i_tx_fail && !i_tx_done && !(|obj_wr))
        |=> $stable(rqst) ##1 (st_r.st == TX_PREP || st_r.blocked || !any_rq))
        else $error("normal mode lost a failed request");

    prio_pick_a: assert property (
        (st_r.st == TX_IDLE && any_rq && !st_r.blocked)
        |=> st_r.st == TX_PREP && st_r.cur == $past(enc_idx))
        else $error("offered object is not the highest priority");

    unblock_a: assert property (
        (st_r.blocked && (i_bus_activity || any_set)) |=> !st_r.blocked)
        else $error("blocked request not re-armed");

    new_content_a: assert property (
        s_reload ##1 s_finish |=> rqst[$past(st_r.cur)] && st_r.st == TX_IDLE)
        else $error("new content cleared by old send");

    clear_set_a: assert property (
        (st_r.st == TX_PREP && !rqst[st_r.cur]) ##1 (i_wr && any_set)
        |=> !st_r.blocked && (|rqst))
        else $error("re-set request not honoured");

endmodule
`default_nettype wire

//--- verification/can_link_node.sv
`timescale 1ns/1ps
`default_nettype none

// Remote CAN node: takes each offered object after a delay, ends the frame later
module can_link_node
    import can_txrq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_valid,
    input wire logic [OBJ_W-1:0] i_tx_obj,
    input wire logic [ID_W-1:0] i_tx_id,
    input wire logic [31:0] i_tx_data,
    input wire logic i_fail,
    input wire logic i_hold,
    output logic o_tx_start,
    output logic o_tx_done,
    output logic o_tx_fail,
    output int o_sends,
    output logic [OBJ_W-1:0] o_last_obj,
    output logic [ID_W-1:0] o_last_id,
    output logic [31:0] o_last_data
);
    // Long start delay so later, higher priority requests can overtake the offer
    localparam int START_DLY = 8;
    localparam int FRAME_LEN = 6;
    logic busy_r;
    int cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Start pulse while offered, then one done or fail pulse per frame
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_r <= 1'b0;
            cnt_r <= 0;
            o_tx_start <= 1'b0;
            o_tx_done <= 1'b0;
            o_tx_fail <= 1'b0;
            o_sends <= 0;
            o_last_obj <= '0;
            o_last_id <= '0;
            o_last_data <= '0;
        end
        else
        begin
            o_tx_start <= 1'b0;
            o_tx_done <= 1'b0;
            o_tx_fail <= 1'b0;
            if (!busy_r)
            begin
                cnt_r <= (i_tx_valid && !i_hold) ? cnt_r + 1 : 0;
                if (i_tx_valid && !i_hold && cnt_r == START_DLY)
                begin
                    o_tx_start <= 1'b1;
                    busy_r <= 1'b1;
                    cnt_r <= 0;
                    o_last_obj <= i_tx_obj;
                    o_last_id <= i_tx_id;
                    o_last_data <= i_tx_data;
                end
            end
            else
            begin
                cnt_r <= cnt_r + 1;
                if (cnt_r == FRAME_LEN)
                begin
                    o_tx_fail <= i_fail; // Disturbed frame on command
                    o_tx_done <= !i_fail;
                    busy_r <= 1'b0;
                    cnt_r <= 0;
                    o_sends <= o_sends + 1;
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- verification/tb_can_txrq.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
    begin \
        comparisons++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("wrong value %s expected %h seen %h", n, e, a); \
        end \
    end

module tb_can_txrq
    import can_txrq_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic bus_act = 1'b0;
    logic fail = 1'b0;
    logic hold = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic tx_start, tx_done, tx_fail, tx_valid;
    logic [OBJ_W-1:0] tx_obj, last_obj;
    logic [ID_W-1:0] tx_id, last_id;
    logic [31:0] tx_data, last_data;
    int sends;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    can_txrq uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_tx_start(tx_start),
        .i_tx_done(tx_done), .i_tx_fail(tx_fail), .i_bus_activity(bus_act),
        .o_tx_valid(tx_valid), .o_tx_obj(tx_obj), .o_tx_id(tx_id), .o_tx_data(tx_data));

    can_link_node link (.i_core_clk(clk), .i_rst_n(rst_n), .i_tx_valid(tx_valid),
        .i_tx_obj(tx_obj), .i_tx_id(tx_id), .i_tx_data(tx_data), .i_fail(fail),
        .i_hold(hold), .o_tx_start(tx_start), .o_tx_done(tx_done), .o_tx_fail(tx_fail),
        .o_sends(sends), .o_last_obj(last_obj), .o_last_id(last_id), .o_last_data(last_data));

    ////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles leave one idle cycle so no strobe is driven twice in a step
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(n, e, v)
    endtask

    task automatic wait_sends(input int n);
        while (sends < n) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [11:0] oa(input int n);
        return OBJ_BASE_OFS + 12'(4 * (n - 1));
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk("ctrl", CTRL_OFS, 32'h0);
        rchk("pend", PEND_OFS, 32'h0);
        rchk("flags1", oa(1), 32'h0);
        rchk("xfer", IF_XFER_OFS, 32'h0);
        rchk("unmapped", 12'h020, 32'h0);
        $display("test reset finished");
        // Sent objects: pending only where enabled
        wr(oa(1), 32'h0000000b);
        wait_sends(1);
        rchk("flags1", oa(1), 32'h0000000c);
        wr(oa(2), 32'h00000003);
        wait_sends(2);
        rchk("flags2", oa(2), 32'h0);
        `CHK("obj", 5'h01, last_obj)
        $display("test send flags finished");
        // Reload through the interface while the old content is on the wire
        wr(IF_ID_OFS, 32'h0abcdef1);
        wr(IF_DATA_OFS, 32'h11223344);
        wr(IF_XFER_OFS, 32'h00000302);
        while (!tx_start) @(posedge clk);
        wr(IF_ID_OFS, 32'h01234567);
        wr(IF_DATA_OFS, 32'h55667788);
        wr(IF_XFER_OFS, 32'h00000302);
        wait_sends(3);
        `CHK("id", 29'h0abcdef1, last_id)
        `CHK("data", 32'h11223344, last_data)
        rchk("flags3", oa(3), 32'h00000003);
        wait_sends(4);
        `CHK("id", 29'h01234567, last_id)
        `CHK("data", 32'h55667788, last_data)
        rchk("flags3", oa(3), 32'h0);
        rchk("ifid", IF_ID_OFS, 32'h01234567);
        rchk("ifdata", IF_DATA_OFS, 32'h55667788);
        $display("test reload finished");
        // Three concurrent requests, lowest number first
        wr(oa(32), 32'h3);
        wr(oa(5), 32'h3);
        wr(oa(2), 32'h3);
        wait_sends(5);
        `CHK("obj", 5'h01, last_obj)
        wait_sends(6);
        `CHK("obj", 5'h04, last_obj)
        wait_sends(7);
        `CHK("obj", 5'h1f, last_obj)
        rchk("pend", PEND_OFS, 32'h0);
        // Normal mode retries a disturbed frame
        fail <= 1'b1;
        wr(oa(1), 32'h3);
        wait_sends(9);
        rchk("flags1", oa(1), 32'h3);
        fail <= 1'b0;
        wait_sends(10);
        rchk("flags1", oa(1), 32'h0);
        $display("test priority finished");
        // No-retransmit mode: failure drops only the request
        wr(CTRL_OFS, 32'h1);
        fail <= 1'b1;
        wr(oa(1), 32'h7);
        wait_sends(11);
        rchk("flags1", oa(1), 32'h6);
        repeat (40) @(posedge clk);
        `CHK("sends", 11, sends)
        fail <= 1'b0;
        wr(oa(1), 32'h3);
        wait_sends(12);
        rchk("flags1", oa(1), 32'h0);
        wr(CTRL_OFS, 32'h0);
        $display("test no retransmit finished");
        // Clear in preparation, then set again
        hold <= 1'b1;
        wr(oa(1), 32'h3);
        while (!tx_valid) @(posedge clk);
        wr(oa(1), 32'h0);
        wr(oa(1), 32'h3);
        rchk("flags1", oa(1), 32'h3);
        `CHK("offer", 1'b1, tx_valid)
        wr(oa(1), 32'h0);
        rd(CTRL_OFS, d);
        `CHK("blocked", 1'b1, d[CTRL_BLK_BIT])
        `CHK("state", 2'h0, d[CTRL_ST_LSB +: 2])
        rchk("flags1", oa(1), 32'h0);
        bus_act <= 1'b1;
        @(posedge clk);
        bus_act <= 1'b0;
        @(posedge clk);
        rd(CTRL_OFS, d);
        `CHK("blocked", 1'b0, d[CTRL_BLK_BIT])
        wr(oa(1), 32'h3);
        while (!tx_valid) @(posedge clk);
        wr(oa(1), 32'h0);
        wr(oa(4), 32'h3);
        rd(CTRL_OFS, d);
        `CHK("blocked", 1'b0, d[CTRL_BLK_BIT])
        `CHK("state", 2'h1, d[CTRL_ST_LSB +: 2])
        `CHK("cur", 5'h03, d[CTRL_CUR_LSB +: OBJ_W])
        hold <= 1'b0;
        wait_sends(13);
        `CHK("obj", 5'h03, last_obj)
        $display("test blocked request finished");
        complete_run();
    end
endmodule

`default_nettype wire
